/* testbench/gposm_pin_watch.sv */
// partner: outside circuit watching the two general pins
// assumes a weak pull-down on each pin while released
module gposm_pin_watch (
    input  wire logic TWO_OUT,
    input  wire logic TWO_OE_N,
    input  wire logic ZERO_OUT,
    input  wire logic ZERO_OE_N,
    output logic      TWO_LVL,
    output logic      ZERO_LVL
);
    timeunit 1ns;
    timeprecision 100ps;
    assign TWO_LVL  = TWO_OE_N ? 1'b0 : TWO_OUT;
    assign ZERO_LVL = ZERO_OE_N ? 1'b0 : ZERO_OUT;
endmodule

/* testbench/gposm_top_tb.sv */
// self-checking bench for the general-pin output source mux
// assumes the pin watcher model and the design package
module gposm_top_tb
    import gposm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // arbitrary value, not a real part code
    localparam logic [7:0] TB_DIE = 8'h3c;
    logic       mclk, rst, rd, wr, dir2, dir0, zoth, moth, dsp, aml, amr;
    logic       cerr, cchg, cmis, sdo, pump, uvh, uvl, osc, prev;
    logic       rvalid, two_out, two_oe_n, zero_out, zero_oe_n, mute, two_lvl, zero_lvl, armed;
    logic [7:0] addr, wdata, rdata, lvl, inv, selb;
    logic [4:0] zsel, msel;
    logic [7:0] rd_q[$];
    logic [4:0] pin_q[$];
    int         bad_count, total_checks, cyc, tog;

    gposm_top #(.DIE_IDENT(TB_DIE)) gposm_top_inst (
        .MCLK(mclk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .PIN_TWO_DIR_OUT(dir2), .PIN_ZERO_DIR_OUT(dir0),
        .PIN_ZERO_SOURCE_SEL(zsel), .PIN_ZERO_OTHER_SRC(zoth), .MUTE_SOURCE_SEL(msel),
        .MUTE_OTHER_SRC(moth), .DSP_PIN_TWO_OUT(dsp), .AUTO_MUTE_LEFT(aml), .AUTO_MUTE_RIGHT(amr),
        .CLK_ERROR(cerr), .CLK_CHANGING(cchg), .CLK_MISSING(cmis), .SERIAL_AUDIO_OUT(sdo),
        .PUMP_CLK(pump), .SOFT_MUTE_UV_HIGH(uvh), .SOFT_MUTE_UV_LOW(uvl), .OSC_CLK_IN(osc),
        .GENERAL_PIN_TWO_OUT(two_out), .GENERAL_PIN_TWO_OE_N(two_oe_n),
        .GENERAL_PIN_ZERO_OUT(zero_out), .GENERAL_PIN_ZERO_OE_N(zero_oe_n), .MUTE_PIN_OUT(mute));

    gposm_pin_watch gposm_pin_watch_inst (
        .TWO_OUT(two_out), .TWO_OE_N(two_oe_n), .ZERO_OUT(zero_out), .ZERO_OE_N(zero_oe_n),
        .TWO_LVL(two_lvl), .ZERO_LVL(zero_lvl));

    // ----------------------------------------
    // compare and verdict
    // ----------------------------------------
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pins(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // drivers and expectations
    // ----------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
        @(negedge mclk);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        rd_q.push_back(e);
        @(negedge mclk);
        rd = 1'b0;
        @(negedge mclk);
    endtask

    function automatic logic [4:0] exp_pins(input logic [4:0] s);
        logic v2;
        logic v0;
        case (s)
            5'h01: v2 = dsp;
            5'h02: v2 = lvl[5];
            5'h03: v2 = aml & amr;
            5'h04: v2 = aml;
            5'h06: v2 = cerr | cchg | cmis;
            5'h07: v2 = sdo;
            5'h0b: v2 = pump;
            5'h0e: v2 = uvh;
            5'h0f: v2 = uvl;
            default: v2 = 1'b0;
        endcase
        v2 = v2 ^ inv[5];
        v0 = ((zsel == 5'h02) ? lvl[3] : zoth) ^ inv[3];
        return {~dir2, dir2 & v2, ~dir0, dir0 & v0, ((msel == 5'h02) ? lvl[4] : moth) ^ inv[4]};
    endfunction

    task automatic pin_step(input logic [4:0] s);
        {dsp, aml, amr, cerr, cchg, cmis, sdo, pump, uvh, uvl, zoth, moth, dir2, dir0} = 14'($urandom);
        zsel = $urandom_range(1) ? 5'h02 : 5'($urandom);
        msel = $urandom_range(1) ? 5'h02 : 5'($urandom);
        pin_q.push_back(exp_pins(s));
        @(negedge mclk);
        @(negedge mclk);
    endtask

    // ----------------------------------------
    // watchers and timeout
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (rvalid === 1'b1 && rd_q.size() != 0)
            chk_data(rdata, rd_q.pop_front());
        if (pin_q.size() != 0)
        begin
            if (armed)
            begin
                chk_pins({two_oe_n, two_lvl, zero_oe_n, zero_lvl, mute}, pin_q.pop_front());
                armed = 1'b0;
            end
            else
                armed = 1'b1;
        end
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            test_done();
        end
    end

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {rst, rd, wr, dir2, dir0, zoth, moth, dsp, aml, amr, cerr, cchg, cmis, sdo, pump, uvh, uvl, osc} = 18'h20000;
        {addr, wdata, lvl, inv, zsel, msel} = '0;
        armed = 1'b0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        void'($urandom(18297));
        for (int i = 0; i < 5; i++)
            reg_rd(8'(OFF_PIN_TWO_SEL + i), (i == 3) ? TB_DIE : 8'h00);
        reg_wr(OFF_DIE_IDENT, ~TB_DIE);
        reg_rd(OFF_DIE_IDENT, TB_DIE);
        for (int n = 0; n < 64; n++)
        begin
            lvl = 8'($urandom);
            inv = 8'($urandom);
            selb = {3'($urandom), 5'(n)};
            reg_wr(OFF_PIN_TWO_SEL, selb);
            reg_wr(OFF_LEVELS, lvl);
            reg_wr(OFF_INVERSION, inv);
            reg_rd(OFF_PIN_TWO_SEL, selb);
            reg_rd(OFF_INVERSION, inv);
            pin_step(5'(n));
            pin_step(5'(n));
        end
        reg_wr(OFF_PIN_TWO_SEL, 8'h11);
        reg_wr(OFF_INVERSION, 8'h00);
        prev = two_out;
        tog = 0;
        for (int i = 0; i < 68; i++)
        begin
            osc = (i < 64) && ((i % 8) >= 4);
            @(negedge mclk);
            if (two_out !== prev)
                tog++;
            prev = two_out;
        end
        chk_data(8'(tog), 8'h04);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        lvl = 8'h00;
        inv = 8'h00;
        reg_rd(OFF_INVERSION, 8'h00);
        reg_rd(OFF_PIN_TWO_SEL, 8'h00);
        reg_rd(OFF_LEVELS, 8'h00);
        pin_step(5'h00);
        reg_wr(OFF_PIN_TWO_SEL, 8'h02);
        lvl = 8'h38;
        reg_wr(OFF_LEVELS, lvl);
        pin_step(5'h02);
        chk_data(8'(rd_q.size() + pin_q.size()), 8'h00);
        test_done();
    end
endmodule

/* verilog/gposm_pkg.sv */
// package for the general-pin output source mux
// assumes one system clock and a byte-wide control port
package gposm_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PIN_TWO_SEL   = 8'h55;
    localparam logic [7:0] OFF_LEVELS        = 8'h56;
    localparam logic [7:0] OFF_INVERSION     = 8'h57;
    localparam logic [7:0] OFF_DIE_IDENT     = 8'h58;

    // ----------------------------------------
    // reset values and field positions
    // ----------------------------------------
    localparam logic [7:0] RST_PIN_TWO_SEL   = 8'h00;
    localparam logic [7:0] RST_LEVELS        = 8'h00;
    localparam logic [7:0] RST_INVERSION     = 8'h00;
    localparam int         SEL_MSB           = 4;
    localparam int         BIT_PIN_TWO       = 5;
    localparam int         BIT_MUTE          = 4;
    localparam int         BIT_PIN_ZERO      = 3;
    localparam logic [1:0] OSC_DIV_LAST      = 2'h1;

    // ----------------------------------------
    // pin-two source codes
    // ----------------------------------------
    typedef enum logic [4:0] {
        SEL_OFF       = 5'b00000,
        SEL_DSP       = 5'b00001,
        SEL_SW_LEVEL  = 5'b00010,
        SEL_MUTE_BOTH = 5'b00011,
        SEL_MUTE_LEFT = 5'b00100,
        SEL_CLK_BAD   = 5'b00110,
        SEL_SER_OUT   = 5'b00111,
        SEL_PUMP_CLK  = 5'b01011,
        SEL_UV_HIGH   = 5'b01110,
        SEL_UV_LOW    = 5'b01111,
        SEL_OSC_DIV4  = 5'b10001
    } gposm_sel_type;

endpackage

/* verilog/gposm_top.sv */
// general-pin output source mux with its control registers
// assumes all inputs synchronous to MCLK; selectors for pin zero and mute kept outside
//
// How it works
// - five-bit selector picks pin-two source; drives pin only in output direction
// - code 0000 gives constant zero; code 0001 passes processor pin-two output
// - code 0010 routes software level bit 5 to pin two
// - code 0011 both channels auto-muted; code 0100 left auto-mute flag
// - code 0110 gives clock error or changing or missing flag
// - code 0111 drives serial audio output stream onto pin two
// - code 1011 drives charge pump clock onto pin two
// - codes 1110 and 1111 give high and low supply-threshold flags
// - code 10001 gives oscillator clock divided by four
// - any unassigned selector code gives constant zero
// - level bit 5 sets pin two level while its selector is 0010
// - level bit 4 sets mute pin level while its selector is 0010
// - level bit 3 sets pin zero level while its selector is 0010
// - inversion bit 5 inverts pin two for any source
// - inversion bit 4 inverts mute pin for any source
// - inversion bit 3 inverts pin zero for any source
module gposm_top
    import gposm_pkg::*;
#(
    // arbitrary value, not a real part code
    parameter logic [7:0] DIE_IDENT = 8'h5a
)(
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    input  wire logic       PIN_TWO_DIR_OUT,
    input  wire logic       PIN_ZERO_DIR_OUT,
    input  wire logic [4:0] PIN_ZERO_SOURCE_SEL,
    input  wire logic       PIN_ZERO_OTHER_SRC,
    input  wire logic [4:0] MUTE_SOURCE_SEL,
    input  wire logic       MUTE_OTHER_SRC,
    input  wire logic       DSP_PIN_TWO_OUT,
    input  wire logic       AUTO_MUTE_LEFT,
    input  wire logic       AUTO_MUTE_RIGHT,
    input  wire logic       CLK_ERROR,
    input  wire logic       CLK_CHANGING,
    input  wire logic       CLK_MISSING,
    input  wire logic       SERIAL_AUDIO_OUT,
    input  wire logic       PUMP_CLK,
    input  wire logic       SOFT_MUTE_UV_HIGH,
    input  wire logic       SOFT_MUTE_UV_LOW,
    input  wire logic       OSC_CLK_IN,
    output logic            GENERAL_PIN_TWO_OUT,
    output logic            GENERAL_PIN_TWO_OE_N,
    output logic            GENERAL_PIN_ZERO_OUT,
    output logic            GENERAL_PIN_ZERO_OE_N,
    output logic            MUTE_PIN_OUT
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] sel_q,   sel_d;
    logic [7:0] level_q, level_d;
    logic [7:0] inv_q,   inv_d;
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;

    always_comb
    begin
        sel_d    = sel_q;
        level_d  = level_q;
        inv_d    = inv_q;
        rdata_d  = rdata_q;
        rvalid_d = REG_RD;
        if (REG_WR)
        begin
            case (REG_ADDR)
                OFF_PIN_TWO_SEL: sel_d   = REG_WDATA;
                OFF_LEVELS:      level_d = REG_WDATA;
                OFF_INVERSION:   inv_d   = REG_WDATA;
                default:         ;
            endcase
        end
        if (REG_RD)
        begin
            case (REG_ADDR)
                OFF_PIN_TWO_SEL: rdata_d = sel_q;
                OFF_LEVELS:      rdata_d = level_q;
                OFF_INVERSION:   rdata_d = inv_q;
                OFF_DIE_IDENT:   rdata_d = DIE_IDENT;
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sel_q    <= RST_PIN_TWO_SEL;
            level_q  <= RST_LEVELS;
            inv_q    <= RST_INVERSION;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            sel_q    <= sel_d;
            level_q  <= level_d;
            inv_q    <= inv_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------
    // oscillator divide by four
    // ----------------------------------------
    logic       osc_prev_q, osc_prev_d;
    logic [1:0] osc_cnt_q,  osc_cnt_d;
    logic       div_q,      div_d;

    always_comb
    begin
        osc_prev_d = OSC_CLK_IN;
        osc_cnt_d  = osc_cnt_q;
        div_d      = div_q;
        if (OSC_CLK_IN && !osc_prev_q)
        begin
            if (osc_cnt_q == OSC_DIV_LAST)
            begin
                osc_cnt_d = 2'h0;
                div_d     = !div_q;
            end
            else
            begin
                osc_cnt_d = osc_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            osc_prev_q <= 1'b0;
            osc_cnt_q  <= 2'h0;
            div_q      <= 1'b0;
        end
        else
        begin
            osc_prev_q <= osc_prev_d;
            osc_cnt_q  <= osc_cnt_d;
            div_q      <= div_d;
        end
    end

    // ----------------------------------------
    // source mux, inversion, pin drivers
    // ----------------------------------------
    logic two_q,  two_d;
    logic two_oe_n_q, two_oe_n_d;
    logic zero_q, zero_d;
    logic zero_oe_n_q, zero_oe_n_d;
    logic mute_q, mute_d;
    logic two_src;
    logic zero_src;
    logic mute_src;

    always_comb
    begin
        case (gposm_sel_type'(sel_q[SEL_MSB:0]))
            SEL_OFF:       two_src = 1'b0;
            SEL_DSP:       two_src = DSP_PIN_TWO_OUT;
            SEL_SW_LEVEL:  two_src = level_q[BIT_PIN_TWO];
            SEL_MUTE_BOTH: two_src = AUTO_MUTE_LEFT && AUTO_MUTE_RIGHT;
            SEL_MUTE_LEFT: two_src = AUTO_MUTE_LEFT;
            SEL_CLK_BAD:   two_src = CLK_ERROR || CLK_CHANGING || CLK_MISSING;
            SEL_SER_OUT:   two_src = SERIAL_AUDIO_OUT;
            SEL_PUMP_CLK:  two_src = PUMP_CLK;
            SEL_UV_HIGH:   two_src = SOFT_MUTE_UV_HIGH;
            SEL_UV_LOW:    two_src = SOFT_MUTE_UV_LOW;
            SEL_OSC_DIV4:  two_src = div_q;
            default:       two_src = 1'b0;
        endcase
        zero_src = (PIN_ZERO_SOURCE_SEL == SEL_SW_LEVEL) ? level_q[BIT_PIN_ZERO] : PIN_ZERO_OTHER_SRC;
        mute_src = (MUTE_SOURCE_SEL == SEL_SW_LEVEL) ? level_q[BIT_MUTE] : MUTE_OTHER_SRC;
        two_d = two_src ^ inv_q[BIT_PIN_TWO];
        zero_d = zero_src ^ inv_q[BIT_PIN_ZERO];
        mute_d = mute_src ^ inv_q[BIT_MUTE];
        two_oe_n_d  = !PIN_TWO_DIR_OUT;
        zero_oe_n_d = !PIN_ZERO_DIR_OUT;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            two_q       <= 1'b0;
            two_oe_n_q  <= 1'b1;
            zero_q      <= 1'b0;
            zero_oe_n_q <= 1'b1;
            mute_q      <= 1'b0;
        end
        else
        begin
            two_q       <= two_d;
            two_oe_n_q  <= two_oe_n_d;
            zero_q      <= zero_d;
            zero_oe_n_q <= zero_oe_n_d;
            mute_q      <= mute_d;
        end
    end

    assign GENERAL_PIN_TWO_OUT   = two_q;
    assign GENERAL_PIN_TWO_OE_N  = two_oe_n_q;
    assign GENERAL_PIN_ZERO_OUT  = zero_q;
    assign GENERAL_PIN_ZERO_OE_N = zero_oe_n_q;
    assign MUTE_PIN_OUT          = mute_q;
    assign REG_RDATA             = rdata_q;
    assign REG_RVALID            = rvalid_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    logic [4:0] s5;
    assign s5 = sel_q[SEL_MSB:0];

    sequence s_level_write;
        REG_WR && REG_ADDR == OFF_LEVELS && REG_WDATA[BIT_PIN_TWO];
    endsequence

    sequence s_sw_route;
        s5 == SEL_SW_LEVEL && !inv_q[BIT_PIN_TWO] && !REG_WR;
    endsequence

    property p_dir_drive;
        PIN_TWO_DIR_OUT != PIN_ZERO_DIR_OUT |=> GENERAL_PIN_TWO_OE_N != GENERAL_PIN_ZERO_OE_N
            && GENERAL_PIN_TWO_OE_N == !$past(PIN_TWO_DIR_OUT);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("pin two enable wrong");

    property p_off_low;
        s5 == SEL_OFF && !inv_q[BIT_PIN_TWO] |=> !GENERAL_PIN_TWO_OUT;
    endproperty
    a_off_low: assert property (p_off_low) else $error("pin two not low when off");

    property p_dsp_pass;
        s5 == SEL_DSP |=> GENERAL_PIN_TWO_OUT == ($past(DSP_PIN_TWO_OUT) ^ $past(inv_q[BIT_PIN_TWO]));
    endproperty
    a_dsp_pass: assert property (p_dsp_pass) else $error("processor output not passed");

    property p_sw_level;
        s_level_write ##1 s_sw_route |=> GENERAL_PIN_TWO_OUT;
    endproperty
    a_sw_level: assert property (p_sw_level) else $error("software level not on pin two");

    property p_mute_both;
        s5 == SEL_MUTE_BOTH && !inv_q[BIT_PIN_TWO] |=> GENERAL_PIN_TWO_OUT == ($past(AUTO_MUTE_LEFT)
            && $past(AUTO_MUTE_RIGHT));
    endproperty
    a_mute_both: assert property (p_mute_both) else $error("both-mute flag wrong");

    property p_clk_bad;
        s5 == SEL_CLK_BAD && !inv_q[BIT_PIN_TWO] && CLK_MISSING |=> GENERAL_PIN_TWO_OUT;
    endproperty
    a_clk_bad: assert property (p_clk_bad) else $error("clock invalid flag missing");

    property p_ser_out;
        s5 == SEL_SER_OUT && inv_q[BIT_PIN_TWO] |=> GENERAL_PIN_TWO_OUT == !$past(SERIAL_AUDIO_OUT);
    endproperty
    a_ser_out: assert property (p_ser_out) else $error("inverted serial output wrong");

    property p_uv_low;
        s5 == SEL_UV_LOW && !inv_q[BIT_PIN_TWO] |=> GENERAL_PIN_TWO_OUT == $past(SOFT_MUTE_UV_LOW);
    endproperty
    a_uv_low: assert property (p_uv_low) else $error("low threshold flag wrong");

    property p_unassigned;
        (s5 == 5'h05 || s5 == 5'h1f) && inv_q[BIT_PIN_TWO] |=> GENERAL_PIN_TWO_OUT;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned code not zero");

    property p_div_rate;
        OSC_CLK_IN && !osc_prev_q && osc_cnt_q == OSC_DIV_LAST |=> div_q != $past(div_q) ##1 $stable(div_q);
    endproperty
    a_div_rate: assert property (p_div_rate) else $error("oscillator divider wrong");

    property p_die_read;
        REG_RD && REG_ADDR == OFF_DIE_IDENT |=> REG_RVALID && REG_RDATA == DIE_IDENT;
    endproperty
    a_die_read: assert property (p_die_read) else $error("die code read wrong");

    property p_zero_level;
        PIN_ZERO_SOURCE_SEL == SEL_SW_LEVEL |=> GENERAL_PIN_ZERO_OUT ==
            ($past(level_q[BIT_PIN_ZERO]) ^ $past(inv_q[BIT_PIN_ZERO]));
    endproperty
    a_zero_level: assert property (p_zero_level) else $error("pin zero level wrong");

    property p_mute_level;
        MUTE_SOURCE_SEL == SEL_SW_LEVEL |=> MUTE_PIN_OUT == ($past(level_q[BIT_MUTE]) ^ $past(inv_q[BIT_MUTE]));
    endproperty
    a_mute_level: assert property (p_mute_level) else $error("mute pin level wrong");

endmodule
